// file: sim/ctl_port_assertions.sv
`timescale 1ns/1ps
module ctl_port_checker (
    // Clock and reset
    input wire clk_i,
    input wire rstn_i,
    // Control port pins
    input wire control_bit_clock_i,
    input wire control_data_in_i,
    input wire address_or_select_pin_i,
    input wire control_data_out_o,
    input wire control_data_oe_o,
    // Device state
    input wire control_port_mode_o,
    input wire spi_mode_o,
    input wire power_down_o,
    input wire powered_up_o,
    input wire common_mode_ref_out_o,
    input wire slow_filter_o,
    input wire [7:0] register_pointer_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Cycles since the power-down bit went low, saturating
    logic [11:0] low_cnt_ff;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) low_cnt_ff <= 12'h000;
        else if (power_down_o) low_cnt_ff <= 12'h000;
        else if (low_cnt_ff != 12'hFFF) low_cnt_ff <= low_cnt_ff + 12'h001;
    end
    sequence cs_fall;
        $fell(address_or_select_pin_i);
    endsequence
    sequence spi_on_soon;
        ##[1:6] spi_mode_o;
    endsequence
    a_spi_entry: assert property (cs_fall |-> spi_on_soon)
        else $error("SPI mode not entered after select fall");
    a_spi_sticky: assert property (spi_mode_o |=> spi_mode_o)
        else $error("SPI mode left without reset");
    a_spi_quiet: assert property (spi_mode_o |-> !control_data_oe_o)
        else $error("Data line driven in SPI mode");
    a_cpm_sticky: assert property (control_port_mode_o |=> control_port_mode_o)
        else $error("Control-port mode dropped");
    a_fast_default: assert property (!control_port_mode_o |-> !slow_filter_o)
        else $error("Slow filter without control-port mode");
    a_ref_low: assert property (power_down_o |-> !common_mode_ref_out_o)
        else $error("Reference up while powered down");
    a_pwrup_time: assert property ($rose(powered_up_o) |->
        (low_cnt_ff >= 12'd1200) && (low_cnt_ff <= 12'd1300))
        else $error("Power-up time off");
    a_ptr_reserved: assert property (register_pointer_o[6:3] == 4'h0)
        else $error("Pointer reserved bits set");
    a_sda_low_only: assert property (control_data_oe_o |-> !control_data_out_o)
        else $error("Data line driven high");
endmodule // ctl_port_checker
bind ctl_port ctl_port_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .control_bit_clock_i(control_bit_clock_i), .control_data_in_i(control_data_in_i),
    .address_or_select_pin_i(address_or_select_pin_i), .control_data_out_o(control_data_out_o),
    .control_data_oe_o(control_data_oe_o), .control_port_mode_o(control_port_mode_o),
    .spi_mode_o(spi_mode_o), .power_down_o(power_down_o), .powered_up_o(powered_up_o),
    .common_mode_ref_out_o(common_mode_ref_out_o), .slow_filter_o(slow_filter_o),
    .register_pointer_o(register_pointer_o));

// file: sim/dac_control_port_startup_test.sv
`timescale 1ns/1ps
module dac_control_port_startup_test;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    wire bit_clk, sda_drv, cs, sda_out, sda_oe, cpm, spi, pwr_dn, pup, cmref, slow;
    wire [7:0] ptr;
    wire sda_line = sda_oe ? sda_out : sda_drv;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] rd;
    // Short wait, still long enough for the claim to land before it ends
    ctl_port #(.WAIT_CYC(1000)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .control_bit_clock_i(bit_clk), .control_data_in_i(sda_line),
        .address_or_select_pin_i(cs), .control_data_out_o(sda_out),
        .control_data_oe_o(sda_oe), .control_port_mode_o(cpm), .spi_mode_o(spi),
        .power_down_o(pwr_dn), .powered_up_o(pup), .common_mode_ref_out_o(cmref),
        .slow_filter_o(slow), .register_pointer_o(ptr));
    host_model host (.clk_i(clk_i), .sda_line_i(sda_line), .bit_clk_o(bit_clk),
        .sda_drv_o(sda_drv), .cs_o(cs));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            close_out();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic tw_put(input logic [7:0] b, input logic exp_ack);
        logic ack;
        host.i2c_byte(b, ack);
        check({7'h00, ack}, {7'h00, exp_ack}, "two-wire ack");
    endtask
    task automatic t_reset();
        check({cpm, spi, pwr_dn, cmref, slow}, 5'h04, "state after reset");
        check(ptr, 8'h00, "pointer after reset");
        $display("t_reset done");
    endtask
    task automatic t_tw_write();
        host.i2c_start();
        tw_put(8'h22, 1'b0);
        tw_put(8'h85, 1'b0);
        tw_put(8'h30, 1'b0);
        tw_put(8'h20, 1'b0);
        host.i2c_stop();
        check({cpm, pwr_dn, slow}, 3'h7, "claim and slow filter");
        check(ptr, 8'h87, "pointer advanced");
        host.i2c_start();
        tw_put(8'h20, 1'b1);
        host.i2c_stop();
        $display("t_tw_write done");
    endtask
    task automatic t_tw_read();
        host.i2c_start();
        tw_put(8'h22, 1'b0);
        tw_put(8'h06, 1'b0);
        host.i2c_stop();
        host.i2c_start();
        tw_put(8'h23, 1'b0);
        host.i2c_read(rd);
        host.i2c_stop();
        check(rd, 8'h20, "read back 06h");
        check(ptr, 8'h06, "pointer held");
        $display("t_tw_read done");
    endtask
    task automatic t_powerup();
        host.i2c_start();
        tw_put(8'h22, 1'b0);
        tw_put(8'h05, 1'b0);
        tw_put(8'h20, 1'b0);
        host.i2c_stop();
        check({cpm, pwr_dn, pup}, 3'h4, "power-down cleared");
        for (int i = 0; i < 2000 && pup !== 1'b1; i++) @(negedge clk_i);
        check({pup, cmref}, 2'h3, "powered up");
        $display("t_powerup done");
    endtask
    task automatic spi_frame(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        host.spi_cs(1'b0);
        host.spi_bits(a, 8);
        host.spi_bits(p, 8);
        host.spi_bits(d, 8);
        host.spi_cs(1'b1);
    endtask
    task automatic t_spi();
        spi_frame(8'h20, 8'h06, 8'h00);
        check({spi, slow}, 2'h2, "SPI write 06h");
        host.spi_cs(1'b0);
        host.spi_bits(8'h20, 8);
        host.spi_bits(8'h60, 4);
        host.spi_cs(1'b1);
        spi_frame(8'h20, 8'h06, 8'h20);
        check({spi, slow}, 2'h3, "after partial frame");
        spi_frame(8'h22, 8'h06, 8'h00);
        check({spi, slow}, 2'h3, "wrong chip address");
        check(ptr, 8'h06, "SPI pointer");
        $display("t_spi done");
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_reset();
        t_tw_write();
        t_tw_read();
        t_powerup();
        t_spi();
        close_out();
    end
endmodule // dac_control_port_startup_test

// file: sim/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire clk_i,
    input wire sda_line_i,
    output logic bit_clk_o,
    output logic sda_drv_o,
    output logic cs_o
);
    // Pins idle high and stand still between frames
    initial begin
        bit_clk_o = 1'b1;
        sda_drv_o = 1'b1;
        cs_o = 1'b1;
    end
    // Half of the 80 ns link period
    task automatic half();
        repeat (5) @(negedge clk_i);
    endtask
    task automatic i2c_start();
        sda_drv_o = 1'b0;
        half();
        bit_clk_o = 1'b0;
    endtask
    task automatic i2c_stop();
        sda_drv_o = 1'b0;
        half();
        bit_clk_o = 1'b1;
        half();
        sda_drv_o = 1'b1;
        half();
    endtask
    // Byte out MSB first, then ack sampled with the line released
    task automatic i2c_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv_o = b[i];
            half();
            bit_clk_o = 1'b1;
            half();
            bit_clk_o = 1'b0;
        end
        sda_drv_o = 1'b1;
        half();
        bit_clk_o = 1'b1;
        ack = sda_line_i;
        half();
        bit_clk_o = 1'b0;
    endtask
    task automatic i2c_read(output logic [7:0] b);
        sda_drv_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            half();
            bit_clk_o = 1'b1;
            b[i] = sda_line_i;
            half();
            bit_clk_o = 1'b0;
        end
        half();
        bit_clk_o = 1'b1;
        half();
        bit_clk_o = 1'b0;
    endtask
    // SPI bits MSB first, device samples on the rising clock
    task automatic spi_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            bit_clk_o = 1'b0;
            sda_drv_o = b[i];
            half();
            bit_clk_o = 1'b1;
            half();
        end
    endtask
    // Data line stays put while select moves
    task automatic spi_cs(input logic lvl);
        cs_o = lvl;
        half();
    endtask
endmodule // host_model

// file: verilog/ctl_port.v
// Notes on behaviour
// - Reset low returns all settings to defaults
// - After reset stay powered down, reference low
// - Clearing power-down bit starts 10us power-up
// - Register 06h bit 5 selects filter roll-off
// - Without control port, use fast roll-off
// - Select falling edge enters SPI, else two-wire
// - SPI mode is write only
// - Wait 100ms after reset, stand-alone default
// - Register 05h bit 5 enters control-port mode
// - Clearing 05h bit 4 begins power-up
// - SPI samples data on clock rising edge
// - SPI frame: address, write bit, pointer, data
// - Pointer advances per byte when increment set
// - Two-wire address 001000 plus address pin
// - Eighth address bit: one read, zero write
// - Two-wire write: pointer byte then data
// - Two-wire read returns pointed register
// - Pointer: increment bit7, address bits 2:0
// - Two-wire follows I2C slave signalling
// - SPI mode sticks until reset or power-down; code clears it only on reset, power-down leaves it set
`timescale 1ns/1ps
`include "ctl_port_map.vh"
module ctl_port #(
    parameter WAIT_CYC = `WAIT_CYCLES
) (
    // Clock and reset
    input wire clk_i,
    input wire rstn_i,
    // Control port pins
    input wire control_bit_clock_i,
    input wire control_data_in_i,
    input wire address_or_select_pin_i,
    output reg control_data_out_o,
    output reg control_data_oe_o,
    // Device state
    output reg control_port_mode_o,
    output reg spi_mode_o,
    output reg power_down_o,
    output reg powered_up_o,
    output reg common_mode_ref_out_o,
    output reg slow_filter_o,
    output reg [7:0] register_pointer_o
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_PTR = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_ACK = 3'h4;
    localparam ST_READ = 3'h5;
    localparam ST_RACK = 3'h6;
    localparam ST_SKIP = 3'h7;
    localparam [11:0] PWRUP_CYC = `PWRUP_CYCLES;

    // Pointer advance, used on write and read paths
    function [7:0] next_ptr;
        input [7:0] p;
        begin
            next_ptr = p[`PTR_AUTOINC_BIT] ? {p[7:3], p[2:0] + 3'h1} : p;
        end
    endfunction

    // Pin synchronisers
    reg [1:0] scl_sync_ff, sda_sync_ff, cs_sync_ff;
    reg scl_d_ff, sda_d_ff, cs_d_ff;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            // Select resets low so a pin tied low never shows a false fall
            cs_sync_ff <= 2'h0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            cs_d_ff <= 1'b0;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], control_bit_clock_i};
            sda_sync_ff <= {sda_sync_ff[0], control_data_in_i};
            cs_sync_ff <= {cs_sync_ff[0], address_or_select_pin_i};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
            cs_d_ff <= cs_sync_ff[1];
        end
    end
    wire scl = scl_sync_ff[1];
    wire sda = sda_sync_ff[1];
    wire cs = cs_sync_ff[1];
    wire scl_rise = scl & ~scl_d_ff;
    wire scl_fall = ~scl & scl_d_ff;
    wire cs_fall = ~cs & cs_d_ff;
    wire tw_start = scl & scl_d_ff & sda_d_ff & ~sda;
    wire tw_stop = scl & scl_d_ff & ~sda_d_ff & sda;

    reg [2:0] state_ff;
    reg [2:0] ret_ff;
    reg [2:0] bitcnt_ff;
    reg [7:0] shift_ff;
    reg rw_ff;
    reg ack_drv_ff;
    reg [24:0] wait_ff;
    reg [11:0] pup_ff;
    reg we;
    reg [7:0] rdata;

    // Register writes go through the store; power reg also kept as flops
    ctl_regs u_regs (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .we_i(we),
        .waddr_i(register_pointer_o[2:0]),
        .wdata_i(shift_ff),
        .raddr_i(register_pointer_o[2:0]),
        .rdata_o(rdata)
    );

    wire [7:0] byte_in = {shift_ff[6:0], sda};
    wire last_bit = (bitcnt_ff == 3'h7);
    wire wr_pwr = we && (register_pointer_o[2:0] == `REG_POWER);
    wire wr_mode3 = we && (register_pointer_o[2:0] == `REG_MODE3);

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= ST_IDLE;
            ret_ff <= ST_IDLE;
            bitcnt_ff <= 3'h0;
            shift_ff <= 8'h00;
            rw_ff <= 1'b0;
            ack_drv_ff <= 1'b0;
            we <= 1'b0;
            spi_mode_o <= 1'b0;
            register_pointer_o <= `PTR_RESET;
            control_data_out_o <= 1'b1;
            control_data_oe_o <= 1'b0;
        end else begin
            we <= 1'b0;
            if (cs_fall) begin
                spi_mode_o <= 1'b1;
            end
            if (spi_mode_o || cs_fall) begin
                control_data_oe_o <= 1'b0;
                if (cs) begin
                    state_ff <= ST_IDLE;
                    bitcnt_ff <= 3'h0;
                end else if (cs_fall) begin
                    state_ff <= ST_ADDR;
                    bitcnt_ff <= 3'h0;
                end else if (scl_rise) begin
                    shift_ff <= byte_in;
                    bitcnt_ff <= bitcnt_ff + 3'h1;
                    if (last_bit) begin
                        case (state_ff)
                            ST_ADDR: begin
                                state_ff <= (byte_in == {`SPI_CHIP_ADDR, 1'b0}) ? ST_PTR
                                            : ST_SKIP;
                            end
                            ST_PTR: begin
                                register_pointer_o <= {byte_in[7], 4'h0, byte_in[2:0]};
                                state_ff <= ST_DATA;
                            end
                            ST_DATA: begin
                                we <= 1'b1;
                            end
                            default: begin
                                state_ff <= ST_SKIP;
                            end
                        endcase
                    end
                end
                if (we) begin
                    register_pointer_o <= next_ptr(register_pointer_o);
                end
            end else begin
                if (we) begin
                    register_pointer_o <= next_ptr(register_pointer_o);
                end
                if (tw_start) begin
                    state_ff <= ST_ADDR;
                    bitcnt_ff <= 3'h0;
                    control_data_oe_o <= 1'b0;
                end else if (tw_stop) begin
                    state_ff <= ST_IDLE;
                    control_data_oe_o <= 1'b0;
                end else if (scl_rise) begin
                    case (state_ff)
                        ST_ADDR, ST_PTR, ST_DATA: begin
                            shift_ff <= byte_in;
                            bitcnt_ff <= bitcnt_ff + 3'h1;
                        end
                        default: begin
                            bitcnt_ff <= bitcnt_ff;
                        end
                    endcase
                    if (last_bit) begin
                        case (state_ff)
                            ST_ADDR: begin
                                if (byte_in[7:1] == {`TW_ADDR_HI, cs}) begin
                                    rw_ff <= byte_in[0];
                                    ack_drv_ff <= 1'b1;
                                    ret_ff <= byte_in[0] ? ST_READ : ST_PTR;
                                    state_ff <= ST_ACK;
                                end else begin
                                    state_ff <= ST_SKIP;
                                end
                            end
                            ST_PTR: begin
                                register_pointer_o <= {byte_in[7], 4'h0, byte_in[2:0]};
                                ack_drv_ff <= 1'b1;
                                ret_ff <= ST_DATA;
                                state_ff <= ST_ACK;
                            end
                            ST_DATA: begin
                                we <= 1'b1;
                                ack_drv_ff <= 1'b1;
                                ret_ff <= ST_DATA;
                                state_ff <= ST_ACK;
                            end
                            default: begin
                                state_ff <= state_ff;
                            end
                        endcase
                    end else if (state_ff == ST_RACK) begin
                        // Host ack keeps reading, nack ends the burst
                        state_ff <= sda ? ST_SKIP : ST_READ;
                        if (!sda) begin
                            register_pointer_o <= next_ptr(register_pointer_o);
                        end
                    end
                end else if (scl_fall) begin
                    case (state_ff)
                        ST_ACK: begin
                            if (ack_drv_ff) begin
                                control_data_out_o <= 1'b0;
                                control_data_oe_o <= 1'b1;
                                ack_drv_ff <= 1'b0;
                            end else begin
                                control_data_oe_o <= 1'b0;
                                bitcnt_ff <= 3'h0;
                                state_ff <= ret_ff;
                                if (ret_ff == ST_READ) begin
                                    control_data_out_o <= rdata[7];
                                    control_data_oe_o <= ~rdata[7];
                                    shift_ff <= {rdata[6:0], 1'b1};
                                    bitcnt_ff <= 3'h1;
                                end
                            end
                        end
                        ST_READ: begin
                            if (bitcnt_ff == 3'h0) begin
                                control_data_oe_o <= 1'b0;
                                state_ff <= ST_RACK;
                            end else begin
                                control_data_out_o <= shift_ff[7];
                                control_data_oe_o <= ~shift_ff[7];
                                shift_ff <= {shift_ff[6:0], 1'b1};
                                bitcnt_ff <= bitcnt_ff + 3'h1;
                            end
                        end
                        ST_RACK: begin
                            control_data_oe_o <= 1'b0;
                        end
                        default: begin
                            control_data_oe_o <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // Startup sequencing
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            control_port_mode_o <= 1'b0;
            power_down_o <= 1'b1;
            powered_up_o <= 1'b0;
            common_mode_ref_out_o <= 1'b0;
            slow_filter_o <= 1'b0;
            wait_ff <= 25'h0000000;
            pup_ff <= 12'h000;
        end else begin
            if (wr_pwr) begin
                if (shift_ff[`PWR_CPM_BIT]) begin
                    control_port_mode_o <= 1'b1;
                end
                power_down_o <= shift_ff[`PWR_DOWN_BIT];
            end
            if (wr_mode3) begin
                slow_filter_o <= shift_ff[`FILT_SLOW_BIT];
            end
            if (!control_port_mode_o && !(wr_pwr && shift_ff[`PWR_CPM_BIT])) begin
                slow_filter_o <= 1'b0;
            end
            if (wait_ff != WAIT_CYC[24:0]) begin
                wait_ff <= wait_ff + 25'h0000001;
            end
            // Stand-alone parts release power-down when the wait expires
            if (wait_ff == WAIT_CYC[24:0] - 25'h0000001 && !control_port_mode_o
                && !wr_pwr) begin
                power_down_o <= 1'b0;
            end
            if (power_down_o) begin
                pup_ff <= 12'h000;
                powered_up_o <= 1'b0;
                common_mode_ref_out_o <= 1'b0;
            end else if (wait_ff == WAIT_CYC[24:0]) begin
                common_mode_ref_out_o <= 1'b1;
                if (pup_ff != PWRUP_CYC) begin
                    pup_ff <= pup_ff + 12'h001;
                end else begin
                    powered_up_o <= 1'b1;
                end
            end
            // Drop the reference on the same edge that power-down returns
            if (wr_pwr && shift_ff[`PWR_DOWN_BIT]) begin
                common_mode_ref_out_o <= 1'b0;
                powered_up_o <= 1'b0;
            end
        end
    end
endmodule // ctl_port

// file: verilog/ctl_port_map.vh
`ifndef CTL_PORT_MAP_VH
`define CTL_PORT_MAP_VH
// Register addresses
`define REG_MODE3 3'h6
`define REG_POWER 3'h5
// Pointer byte fields
`define PTR_AUTOINC_BIT 7
`define PTR_RESET 8'h00
// Power register fields and claim value
`define PWR_CPM_BIT 5
`define PWR_DOWN_BIT 4
`define PWR_CLAIM 8'h30
// Filter select field in register 06h
`define FILT_SLOW_BIT 5
// Chip address
`define SPI_CHIP_ADDR 7'h10
`define TW_ADDR_HI 6'h08
// Timing
`define CLK_MHZ 125
`define WAIT_MS 100
`define WAIT_CYCLES (`WAIT_MS * 1000 * `CLK_MHZ)
`define PWRUP_US 10
`define PWRUP_CYCLES (`PWRUP_US * `CLK_MHZ)
`endif

// file: verilog/ctl_regs.v
`timescale 1ns/1ps
// Eight-entry register store, registered read data
module ctl_regs (
    // Clock and reset
    input wire clk_i,
    input wire rstn_i,
    // Write port
    input wire we_i,
    input wire [2:0] waddr_i,
    input wire [7:0] wdata_i,
    // Read port
    input wire [2:0] raddr_i,
    output reg [7:0] rdata_o
);
    reg [7:0] mem_ff [0:7];
    integer i;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (i = 0; i < 8; i = i + 1) begin
                mem_ff[i] <= 8'h00;
            end
            rdata_o <= 8'h00;
        end else begin
            if (we_i) begin
                mem_ff[waddr_i] <= wdata_i;
            end
            rdata_o <= mem_ff[raddr_i];
        end
    end
endmodule // ctl_regs
